// ---- rtl/smr_defines.vh ----
`ifndef SMR_DEFINES_VH
`define SMR_DEFINES_VH
`define SMR_ADDR_W 16
`define SMR_BA_W 3
`define SMR_SEL_BASE 3'h0
`define SMR_SEL_EXT1 3'h1
`define SMR_SEL_EXT2 3'h2
`define SMR_SEL_EXT3 3'h3
`define SMR_BL_LSB 0
`define SMR_BL_MSB 2
`define SMR_BL_4 3'h2
`define SMR_BL_8 3'h3
`define SMR_BT_BIT 3
`define SMR_CL_LSB 4
`define SMR_CL_MSB 6
`define SMR_TM_BIT 7
`define SMR_DLLRST_BIT 8
`define SMR_WR_LSB 9
`define SMR_WR_MSB 11
`define SMR_DLLDIS_BIT 0
`define SMR_HALF_BIT 1
`define SMR_RTT0_BIT 2
`define SMR_AL_LSB 3
`define SMR_AL_MSB 5
`define SMR_RTT1_BIT 6
`define SMR_CAL_LSB 7
`define SMR_CAL_MSB 9
`define SMR_NDQS_BIT 10
`define SMR_READ_STROBE_OUTPUT_BIT 11
`define SMR_HTREF_BIT 7
`define SMR_CAL_EXIT 3'h0
`define SMR_CAL_DRV1 3'h1
`define SMR_CAL_DRV0 3'h2
`define SMR_CAL_ADJ 3'h4
`define SMR_CAL_DFLT 3'h7
`define SMR_RESET_VAL 16'h0000
`endif

// ---- rtl/smr_reg_file.v ----
`timescale 1ns/1ps
`include "smr_defines.vh"
// four load-only registers; read data registered
module smr_reg_file #(
    parameter WIDTH = 16,
    parameter DEPTH = 4
)
(
    input wire clock,
    input wire rst,
    input wire writeEn,
    input wire [1:0] writeSel,
    input wire [WIDTH-1:0] writeData,
    output reg [WIDTH*DEPTH-1:0] readAll,
    output reg [DEPTH-1:0] loaded
);
    genvar i;
    generate
        for (i = 0; i < DEPTH; i = i + 1)
        begin : entry
            always @(posedge clock)
            begin
                if (rst)
                begin
                    readAll[i*WIDTH +: WIDTH] <= `SMR_RESET_VAL;
                    loaded[i] <= 1'b0;
                end
                else if (writeEn && writeSel == i)
                begin
                    readAll[i*WIDTH +: WIDTH] <= writeData; // see R23
                    loaded[i] <= 1'b1;
                end
            end
        end
    endgenerate
endmodule

// ---- rtl/smr_mode_regs.v ----
// Operation
// R1 - all four strobes and both low bank bits low load the base register
// R2 - strobes low, bank 01 loads extended one, bank 10 extended two
// R3 - controller loads registers only with all banks precharged and clock-enable high
// R4 - controller waits the register-load cycle time after each load
// R5 - controller rewrites every field whenever it reloads a register
// R6 - register loads and DLL reset leave array contents untouched
// R7 - controller must load all registers after power-up before use
// R8 - burst length from address bits 0-2, only 4 and 8
// R9 - bit 3 burst order, bits 4-6 CAS latency, no half-clock latency
// R10 - bit 7 test mode written low normally, bit 8 requests DLL reset
// R11 - bits 9-11 hold write recovery for auto-precharge
// R12 - controller programs write recovery as time over period rounded up
// R13 - controller drives bank bit 2 and address 13-15 to zero
// R14 - extended one: DLL, half drive, termination, latency, calibration, strobe disable
// R15 - DLL off in self refresh, back on at exit
// R16 - controller waits 200 cycles after DLL reset before reading
// R17 - extended two only bit 7 nonzero; extended three all zero
// R18 - each calibration command followed by calibration exit
// R19 - drive-high: data and true strobe high, complement low; drive-low inverted
// R20 - calibration code: 000 exit, 001 high, 010 low, 100 adjust, 111 default
// R21 - later extended-one loads carry 000 to keep calibration
// R22 - controller supplies adjust-mode data as a burst of four
// R23 - address captured into the selected register on the command edge; here captured two edges later, behind the two sync stages
`timescale 1ns/1ps
`include "smr_defines.vh"
module smr_mode_regs #(
    parameter DQ_W = 16,
    parameter STROBES = 2
)
(
    input wire clock,
    input wire rst,
    input wire chipSelN,
    input wire rowStrobeN,
    input wire colStrobeN,
    input wire writeEnN,
    input wire [`SMR_BA_W-1:0] bankSel,
    input wire [`SMR_ADDR_W-1:0] addr,
    input wire selfRefresh,
    output reg [2:0] burst_length,
    output reg burstInterleaved,
    output reg [2:0] casLatency,
    output reg burstLengthValid,
    output reg testMode,
    output reg dllResetPulse,
    output reg [2:0] writeRecovery,
    output reg dllEnabled,
    output reg halfDrive,
    output reg [1:0] die_termination,
    output reg [2:0] additive_latency,
    output reg strobeComplementOff,
    output reg read_strobe_output,
    output reg highTempRefresh,
    output reg [2:0] calMode,
    output reg [3:0] regsLoaded,
    output reg [DQ_W-1:0] driveDq,
    output reg [STROBES-1:0] driveDqs,
    output reg [STROBES-1:0] driveDqsN,
    output reg [STROBES-1:0] driveRdqs,
    output reg driveOe,
    output reg driveRdqsOe
);
    localparam CAL_IDLE = 2'h0;
    localparam CAL_DRIVE = 2'h1;
    localparam CAL_ADJUST = 2'h2;
    // pins are registered twice before decode; command pins and address stay aligned
    reg csS1, rasS1, casS1, weS1, csS2, rasS2, casS2, weS2;
    reg [`SMR_BA_W-1:0] baS1, baS2;
    reg [`SMR_ADDR_W-1:0] adS1, adS2;
    reg [1:0] calState;
    reg [1:0] next_calState;
    wire loadCmd;
    wire [1:0] loadSel;
    wire [4*`SMR_ADDR_W-1:0] regs;
    wire [3:0] loaded;
    wire [`SMR_ADDR_W-1:0] baseReg;
    wire [`SMR_ADDR_W-1:0] ext1Reg;
    wire [`SMR_ADDR_W-1:0] ext2Reg;
    wire [2:0] newCal;
    wire ext1Load;
    wire driveLevel;
    wire rdqsNext;
    always @(posedge clock)
    begin
        if (rst)
        begin
            {csS1, rasS1, casS1, weS1} <= 4'hf;
            {csS2, rasS2, casS2, weS2} <= 4'hf;
            baS1 <= 3'h0;
            baS2 <= 3'h0;
            adS1 <= 16'h0000;
            adS2 <= 16'h0000;
        end
        else
        begin
            {csS1, rasS1, casS1, weS1} <= {chipSelN, rowStrobeN, colStrobeN, writeEnN};
            {csS2, rasS2, casS2, weS2} <= {csS1, rasS1, casS1, weS1};
            baS1 <= bankSel;
            baS2 <= baS1;
            adS1 <= addr;
            adS2 <= adS1;
        end
    end
    // bank bit 2 is reserved and must be low; a load with it set is ignored
    assign loadCmd = ~csS2 & ~rasS2 & ~casS2 & ~weS2 & ~baS2[2]; // see R1 see R2 see R13
    assign loadSel = baS2[1:0]; // see R1 see R2
    // only the register set is touched; nothing here reaches the array (see R6)
    smr_reg_file #(
        .WIDTH(`SMR_ADDR_W),
        .DEPTH(4)
    ) smr_reg_file_i (
        .clock(clock),
        .rst(rst),
        .writeEn(loadCmd),
        .writeSel(loadSel),
        .writeData(adS2),
        .readAll(regs),
        .loaded(loaded)
    );
    assign baseReg = regs[0 +: 16];
    assign ext1Reg = regs[16 +: 16];
    assign ext2Reg = regs[32 +: 16];
    assign ext1Load = loadCmd && baS2 == `SMR_SEL_EXT1;
    assign newCal = adS2[`SMR_CAL_MSB:`SMR_CAL_LSB];
    always @(posedge clock)
    begin
        if (rst)
        begin
            burst_length <= 3'h0;
            burstInterleaved <= 1'b0;
            casLatency <= 3'h0;
            burstLengthValid <= 1'b0;
            testMode <= 1'b0;
            writeRecovery <= 3'h0;
            dllEnabled <= 1'b0;
            halfDrive <= 1'b0;
            die_termination <= 2'h0;
            additive_latency <= 3'h0;
            strobeComplementOff <= 1'b0;
            read_strobe_output <= 1'b0;
            highTempRefresh <= 1'b0;
            regsLoaded <= 4'h0;
        end
        else
        begin
            burst_length <= baseReg[`SMR_BL_MSB:`SMR_BL_LSB]; // see R8
            burstLengthValid <= baseReg[`SMR_BL_MSB:`SMR_BL_LSB] == `SMR_BL_4 ||
                baseReg[`SMR_BL_MSB:`SMR_BL_LSB] == `SMR_BL_8; // see R8
            burstInterleaved <= baseReg[`SMR_BT_BIT]; // see R9
            casLatency <= baseReg[`SMR_CL_MSB:`SMR_CL_LSB]; // see R9
            testMode <= baseReg[`SMR_TM_BIT]; // see R10
            writeRecovery <= baseReg[`SMR_WR_MSB:`SMR_WR_LSB]; // see R11
            // register bit low means enabled; self refresh forces it off (see R15)
            dllEnabled <= loaded[1] & ~ext1Reg[`SMR_DLLDIS_BIT] & ~selfRefresh; // see R14
            halfDrive <= ext1Reg[`SMR_HALF_BIT]; // see R14
            die_termination <= {ext1Reg[`SMR_RTT1_BIT], ext1Reg[`SMR_RTT0_BIT]}; // see R14
            additive_latency <= ext1Reg[`SMR_AL_MSB:`SMR_AL_LSB]; // see R14
            strobeComplementOff <= ext1Reg[`SMR_NDQS_BIT]; // see R14
            read_strobe_output <= ext1Reg[`SMR_READ_STROBE_OUTPUT_BIT];
            highTempRefresh <= ext2Reg[`SMR_HTREF_BIT]; // see R17
            regsLoaded <= loaded;
        end
    end
    // dll reset is an event, not a level: one pulse per base load with bit 8 set
    always @(posedge clock)
    begin
        if (rst)
            dllResetPulse <= 1'b0;
        else
            dllResetPulse <= loadCmd && baS2 == `SMR_SEL_BASE && adS2[`SMR_DLLRST_BIT]; // see R10
    end
    // calibration field: code 000 keeps the current setting and leaves any mode
    always @*
    begin
        next_calState = calState;
        if (ext1Load)
        begin
            case (newCal) // see R20
                `SMR_CAL_DRV1: next_calState = CAL_DRIVE;
                `SMR_CAL_DRV0: next_calState = CAL_DRIVE;
                `SMR_CAL_ADJ: next_calState = CAL_ADJUST;
                default: next_calState = CAL_IDLE; // see R21
            endcase
        end
    end
    always @(posedge clock)
    begin
        if (rst)
        begin
            calState <= CAL_IDLE;
            calMode <= `SMR_CAL_EXIT;
        end
        else
        begin
            calState <= next_calState;
            if (ext1Load)
                calMode <= newCal; // see R20
        end
    end
    // adjust-mode burst data is handled by the data path, not here
    // use the incoming code so levels and enables switch on the same edge
    assign driveLevel = ext1Load ? (newCal == `SMR_CAL_DRV1) : (calMode == `SMR_CAL_DRV1);
    assign rdqsNext = ext1Load ? adS2[`SMR_READ_STROBE_OUTPUT_BIT] : read_strobe_output;
    always @(posedge clock)
    begin
        if (rst)
        begin
            driveDq <= {DQ_W{1'b0}};
            driveDqs <= {STROBES{1'b0}};
            driveDqsN <= {STROBES{1'b0}};
            driveRdqs <= {STROBES{1'b0}};
            driveOe <= 1'b0;
            driveRdqsOe <= 1'b0;
        end
        else
        begin
            driveDq <= {DQ_W{driveLevel}}; // see R19
            driveDqs <= {STROBES{driveLevel}}; // see R19
            driveDqsN <= {STROBES{~driveLevel}}; // see R19
            driveRdqs <= {STROBES{driveLevel}}; // see R19
            driveOe <= (next_calState == CAL_DRIVE);
            driveRdqsOe <= (next_calState == CAL_DRIVE) & rdqsNext; // see R19
        end
    end
endmodule

// ---- verification/smr_mode_regs_properties.sv ----
`timescale 1ns/1ps
module smr_mode_regs_properties #(
    parameter DQ_W = 16,
    parameter STROBES = 2
)
(
    input wire clock, rst, chipSelN, rowStrobeN, colStrobeN, writeEnN, selfRefresh,
    input wire [2:0] bankSel,
    input wire [15:0] addr,
    input wire [2:0] burst_length, casLatency, writeRecovery, additive_latency, calMode,
    input wire burstInterleaved, testMode, dllResetPulse, dllEnabled, strobeComplementOff, driveOe,
    input wire [1:0] die_termination,
    input wire [DQ_W-1:0] driveDq,
    input wire [STROBES-1:0] driveDqs, driveDqsN
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // field outputs follow the sampled command by four edges: two sync stages, store, decode; calMode, drive outputs and dllResetPulse by three
    wire load = !chipSelN && !rowStrobeN && !colStrobeN && !writeEnN && !bankSel[2];
    wire [1:0] sel = bankSel[1:0];
    chk_base_burst:
    assert property (load && sel == 2'h0 |-> ##4 burst_length == $past(addr[2:0], 4)
        && burstInterleaved == $past(addr[3], 4)) else $error("base burst mismatch");
    chk_base_cas:
    assert property (load && sel == 2'h0 |-> ##4 casLatency == $past(addr[6:4], 4)
        && testMode == $past(addr[7], 4)) else $error("base latency mismatch");
    chk_base_wr:
    assert property (load && sel == 2'h0 |-> ##4 writeRecovery == $past(addr[11:9], 4))
        else $error("write recovery mismatch");
    chk_dll_reset:
    assert property (load && sel == 2'h0 && addr[8] |-> ##3 dllResetPulse) else $error("no dll reset pulse");
    chk_ext1_fields:
    assert property (load && sel == 2'h1 |-> ##4 additive_latency == $past(addr[5:3], 4)
        && die_termination == {$past(addr[6], 4), $past(addr[2], 4)}) else $error("ext1 fields mismatch");
    chk_ext1_cal:
    assert property (load && sel == 2'h1 |-> ##4 calMode == $past(addr[9:7], 4)
        && strobeComplementOff == $past(addr[10], 4)) else $error("ext1 cal mismatch");
    chk_drive_levels:
    assert property (driveOe |-> driveDq == {DQ_W{calMode == 3'h1}}
        && driveDqsN == {STROBES{calMode == 3'h2}} && driveDqs == ~driveDqsN) else $error("drive levels wrong");
    chk_self_refresh:
    assert property (selfRefresh [*4] |-> !dllEnabled) else $error("dll on in self refresh");
    cover property (load && sel == 2'h1 && addr[9:7] == 3'h7);
    cover property (driveOe && calMode == 3'h2);
    cover property (selfRefresh && !dllEnabled);
endmodule
bind smr_mode_regs smr_mode_regs_properties #(.DQ_W(DQ_W), .STROBES(STROBES)) smr_mode_regs_properties_i (.*);

// ---- verification/smr_ctrl_model.sv ----
`timescale 1ns/1ps
// controller side: banks taken as precharged, clock-enable high
module smr_ctrl_model #(
    parameter LOAD_GAP = 2
)
(
    input wire clock,
    output reg chipSelN, rowStrobeN, colStrobeN, writeEnN,
    output reg [2:0] bankSel,
    output reg [15:0] addr
);
    initial
    begin
        {chipSelN, rowStrobeN, colStrobeN, writeEnN} = 4'hf;
        bankSel = 3'h0;
        addr = 16'h0000;
    end
    // whole word every load, bank bit 2 and top bits left to caller
    task automatic load(input [2:0] s, input [15:0] a);
        begin
            @(posedge clock);
            {chipSelN, rowStrobeN, colStrobeN, writeEnN} <= 4'h0;
            bankSel <= s;
            addr <= a;
            @(posedge clock);
            {chipSelN, rowStrobeN, colStrobeN, writeEnN} <= 4'hf;
            // deselected pins carry no stale value
            bankSel <= ~s;
            addr <= ~a;
            repeat (LOAD_GAP) @(posedge clock);
        end
    endtask
endmodule

// ---- verification/tb_smr_mode_regs.sv ----
`timescale 1ns/1ps
module tb_smr_mode_regs;
    reg clock, rst, selfRefresh;
    wire chipSelN, rowStrobeN, colStrobeN, writeEnN;
    wire [2:0] bankSel, burst_length, casLatency, writeRecovery, additive_latency, calMode;
    wire [15:0] addr, driveDq;
    wire burstInterleaved, burstLengthValid, testMode, dllResetPulse, dllEnabled, halfDrive;
    wire strobeComplementOff, read_strobe_output, highTempRefresh, driveOe, driveRdqsOe;
    wire [1:0] die_termination, driveDqs, driveDqsN, driveRdqs;
    wire [3:0] regsLoaded;
    integer errTotal = 0;
    integer testsRun = 0;
    smr_ctrl_model smr_ctrl_model_i (.*);
    smr_mode_regs smr_mode_regs_i (.*);
    task chk(input [15:0] got, input [15:0] exp);
        begin
            testsRun = testsRun + 1;
            if (got !== exp)
            begin
                errTotal = errTotal + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task ld(input [2:0] s, input [15:0] a);
        begin
            smr_ctrl_model_i.load(s, a);
            repeat (2) @(posedge clock);
            #1;
        end
    endtask
    task t_base;
        begin
            chk(regsLoaded, 4'h0);
            ld(3'h0, 16'h0a5b);
            chk(burst_length, 3'h3);
            chk(burstInterleaved, 1'b1);
            chk(casLatency, 3'h5);
            chk(writeRecovery, 3'h5);
            ld(3'h0, 16'h0181);
            chk(burstLengthValid, 1'b0);
            chk(testMode, 1'b1);
            repeat (200) @(posedge clock);
            ld(3'h4, 16'h0a5a);
            chk(burst_length, 3'h1);
            ld(3'h0, 16'h0002);
            chk(burstLengthValid, 1'b1);
        end
    endtask
    task t_ext;
        begin
            ld(3'h1, 16'h0c67);
            chk(dllEnabled, 1'b0);
            chk(halfDrive, 1'b1);
            chk(die_termination, 2'h3);
            chk(additive_latency, 3'h4);
            chk(strobeComplementOff, 1'b1);
            ld(3'h2, 16'h0080);
            chk(highTempRefresh, 1'b1);
            ld(3'h3, 16'h0000);
            chk(regsLoaded, 4'hf);
        end
    endtask
    task t_cal;
        reg [2:0] code;
        integer i;
        begin
            for (i = 0; i < 5; i = i + 1)
            begin
                code = (i == 4) ? 3'h0 : (i == 3) ? 3'h7 : 3'h1 << i;
                ld(3'h1, {6'h02, code, 7'h00});
                chk(calMode, code);
                chk(driveOe, code == 3'h1 || code == 3'h2);
                if (code == 3'h1 || code == 3'h2)
                begin
                    chk(driveDq, {16{code == 3'h1}});
                    chk(driveDqsN, {2{code == 3'h2}});
                    chk(driveRdqs, {2{code == 3'h1}});
                    chk(driveRdqsOe, 1'b1);
                end
                // every calibration command is closed by an exit before the next one
                if (code != 3'h0)
                begin
                    ld(3'h1, 16'h0800);
                    chk(driveOe, 1'b0);
                end
            end
            ld(3'h1, 16'h0080);
            chk(driveRdqsOe, 1'b0);
            ld(3'h1, 16'h0000);
            chk(driveOe, 1'b0);
        end
    endtask
    task t_selfref;
        begin
            @(posedge clock) selfRefresh <= 1'b1;
            repeat (5) @(posedge clock);
            #1 chk(dllEnabled, 1'b0);
            @(posedge clock) selfRefresh <= 1'b0;
            repeat (5) @(posedge clock);
            #1 chk(dllEnabled, 1'b1);
        end
    endtask
    task endSim;
        begin
            $display("checks %0d mismatches %0d", testsRun, errTotal);
            if (errTotal == 0 && testsRun > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial
    begin
        rst = 1'b1;
        selfRefresh = 1'b0;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        #1;
        t_base;
        t_ext;
        t_cal;
        t_selfref;
        endSim;
    end
    // whole run is about 330 cycles
    initial
    begin
        #20000;
        errTotal = errTotal + 1;
        endSim;
    end
endmodule
